/* pkg/cwu_defs.svh */
/*
 holds offsets, field positions, reset values and codes of the waveform unit.
 assumes inclusion by bare name from the package and the design file.
*/
// Contract
// - restart after shutdown is by software or automatic, chosen by restart enable
// - software clear of shutdown status is ignored while a selected input is low-active
// - overrides hold after status clears until the first rising input event
// - with auto-restart on, status clears itself once all shutdown sources go inactive
// - enable bit 7 of control zero turns generator on; resets to zero
// - load request bit 6 loads buffered dead bands at next input event, then self-clears; the code loads only the band of that event's edge
// - load request accepted only while already enabled, not in the enabling write
// - three-bit mode: steering, sync steering, forward, reverse, half, push-pull; rest reserved
// - polarity bits 3..0 of control one invert outputs D,C,B,A when set
// - rising dead band holds six-bit delay after rising event; unchanged by resets
// - falling dead band holds six-bit delay after falling event; upper bits unused
// - shutdown status bit 7 is set by hardware while shutdown is in effect
// - B/D override: 11 high, 10 low, 01 high impedance, 00 inactive level
// - A/C override uses same encoding for outputs A and C
// - status may be written while disabled to force overrides until next rising edge
// - unimplemented bits ignore writes and read zero
// - shutdown inputs are level sensitive and block clearing while active
// - polarity does not alter override levels
// - dead bands double-buffered: immediate when disabled, on load request when enabled
`ifndef CWU_DEFS_SVH
`define CWU_DEFS_SVH
// ----------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------
`define CWU_OFF_CTRL0     12'h000
`define CWU_OFF_CTRL1     12'h004
`define CWU_OFF_RISE_DB   12'h008
`define CWU_OFF_FALL_DB   12'h00C
`define CWU_OFF_SDCTRL0   12'h010
`define CWU_OFF_SDSEL     12'h014
// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define CWU_EN_BIT        7
`define CWU_LD_BIT        6
`define CWU_IN_BIT        5
`define CWU_SD_BIT        7
`define CWU_REN_BIT       6
`define CWU_BD_LSB        4
`define CWU_AC_LSB        2
// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define CWU_RST_CTRL0     8'h00
`define CWU_RST_CTRL1     4'h0
`define CWU_RST_SDCTRL0   8'h14
`define CWU_RST_SDSEL     6'h00
`define CWU_RST_DB        6'h00
// override level codes
`define CWU_OVR_HIGH      2'h3
`define CWU_OVR_LOW       2'h2
`define CWU_OVR_HIZ       2'h1
`endif

/* pkg/cwu_pkg.sv */
/*
 holds the types of the waveform unit.
 assumes cwu_defs.svh is on the include path.
*/
`include "cwu_defs.svh"
package cwu_pkg;
   // operating modes
   typedef enum logic [2:0] {
      CWU_STEER      = 3'b000,
      CWU_SYNC_STEER = 3'b001,
      CWU_FWD_FULL   = 3'b010,
      CWU_REV_FULL   = 3'b011,
      CWU_HALF       = 3'b100,
      CWU_PUSH_PULL  = 3'b101,
      CWU_RSVD6      = 3'b110,
      CWU_RSVD7      = 3'b111
   } cwu_mode_t;
   // restart tracking
   typedef enum logic [1:0] {
      CWU_RUN   = 2'b00,
      CWU_SHUT  = 2'b01,
      CWU_WAIT  = 2'b10
   } cwu_state_t;
endpackage

/* rtl/cwu_top.sv */
/*
 holds the complementary waveform unit: apb registers, auto-shutdown and
 restart, double-buffered dead bands, mode steering and output polarity.
 assumes the data and shutdown inputs are synchronous to clock_in.
*/
// The APB interface to the registers and the address map were decided locally.
`include "cwu_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module cwu_top #(
   parameter int DB_W = 6
) (
   input  wire logic        clock_in,
   input  wire logic        rst_n_in,
   input  wire logic        clk_en_in,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [11:0] paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic [31:0]      prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   input  wire logic        data_in,
   input  wire logic [5:0]  shutdown_src_n_in,
   output logic [3:0]       out_level_out,
   output logic [3:0]       out_oe_out
);
   import cwu_pkg::*;

   // elaboration check: dead-band field is six bits wide
   if (DB_W != 6) begin : g_bad_width
      $error("cwu_top: DB_W must be 6");
   end

   // ----------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------
   logic            en_ff;
   logic            ld_ff;
   cwu_mode_t       mode_ff;
   logic [3:0]      pol_ff;
   logic [DB_W-1:0] rise_shadow_ff;
   logic [DB_W-1:0] fall_shadow_ff;
   logic [DB_W-1:0] rise_active_ff;
   logic [DB_W-1:0] fall_active_ff;
   logic            sd_ff;
   logic            ren_ff;
   logic [1:0]      bd_override_level_ff;
   logic [1:0]      ac_override_level_ff;
   logic [5:0]      sd_sel_ff;
   cwu_state_t      state_ff;
   logic            data_d_ff;
   logic [DB_W-1:0] cnt_ff;
   logic            rise_ok_ff;
   logic            fall_ok_ff;
   logic            fwd_ff;

   // ----------------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------------
   logic wr_acc;
   logic rd_acc;
   logic hit;
   logic rise_evt;
   logic fall_evt;
   logic src_active;
   logic [7:0] rd_byte;

   assign wr_acc   = psel_in & penable_in & pwrite_in & clk_en_in;
   assign rd_acc   = psel_in & penable_in & ~pwrite_in & clk_en_in;
   assign rise_evt = data_in & ~data_d_ff;
   assign fall_evt = ~data_in & data_d_ff;
   // inputs are active low; a low selected source holds shutdown
   assign src_active = |(sd_sel_ff & ~shutdown_src_n_in);

   // address decode for the read mux
   always_comb begin
      hit     = 1'b1;
      rd_byte = 8'h00;
      case (paddr_in)
         `CWU_OFF_CTRL0:   rd_byte = {en_ff, ld_ff, 3'b000, mode_ff};
         `CWU_OFF_CTRL1:   rd_byte = {2'b00, data_in, 1'b0, pol_ff};
         `CWU_OFF_RISE_DB: rd_byte = {2'b00, rise_shadow_ff};
         `CWU_OFF_FALL_DB: rd_byte = {2'b00, fall_shadow_ff};
         `CWU_OFF_SDCTRL0: rd_byte = {sd_ff, ren_ff, bd_override_level_ff,
                                      ac_override_level_ff, 2'b00};
         `CWU_OFF_SDSEL:   rd_byte = {2'b00, sd_sel_ff};
         default:          hit = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------------
   // apb slave: one wait cycle, pready registered
   // ----------------------------------------------------------------------
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pready_out  <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out  <= 32'h0000_0000;
      end else if (clk_en_in) begin
         pready_out  <= psel_in & penable_in & ~pready_out;
         pslverr_out <= psel_in & penable_in & ~pready_out & ~hit;
         if (psel_in & penable_in & ~pready_out & ~pwrite_in) begin
            prdata_out <= {24'h00_0000, rd_byte};
         end
      end
   end

   logic wr_fire;
   assign wr_fire = wr_acc & pready_out;

   // control zero: enable, load request, mode
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         en_ff   <= 1'b0;
         ld_ff   <= 1'b0;
         mode_ff <= CWU_STEER;
      end else if (clk_en_in) begin
         if (wr_fire && paddr_in == `CWU_OFF_CTRL0) begin
            en_ff   <= pwdata_in[`CWU_EN_BIT];
            mode_ff <= cwu_mode_t'(pwdata_in[2:0]);
            // request only when already enabled before this write
            if (pwdata_in[`CWU_LD_BIT] && en_ff) begin
               ld_ff <= 1'b1;
            end
         end
         // a load that fires clears the request; a new write keeps priority
         else if (ld_ff && (rise_evt || fall_evt)) begin
            ld_ff <= 1'b0;
         end
         if (!en_ff) begin
            ld_ff <= 1'b0;
         end
      end
   end

   // polarity and shutdown source selection
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pol_ff    <= `CWU_RST_CTRL1;
         sd_sel_ff <= `CWU_RST_SDSEL;
      end else if (clk_en_in && wr_fire) begin
         if (paddr_in == `CWU_OFF_CTRL1) begin
            pol_ff <= pwdata_in[3:0];
         end
         if (paddr_in == `CWU_OFF_SDSEL) begin
            sd_sel_ff <= pwdata_in[5:0];
         end
      end
   end

   // dead-band shadows: no reset, they keep their value across resets
   always_ff @(posedge clock_in) begin
      if (clk_en_in && wr_fire) begin
         if (paddr_in == `CWU_OFF_RISE_DB) begin
            rise_shadow_ff <= pwdata_in[DB_W-1:0];
         end
         if (paddr_in == `CWU_OFF_FALL_DB) begin
            fall_shadow_ff <= pwdata_in[DB_W-1:0];
         end
      end
   end

   // active dead bands: follow shadows while off, load on request when on
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rise_active_ff <= `CWU_RST_DB;
         fall_active_ff <= `CWU_RST_DB;
      end else if (clk_en_in) begin
         if (!en_ff) begin
            rise_active_ff <= rise_shadow_ff;
            fall_active_ff <= fall_shadow_ff;
         end else if (ld_ff && rise_evt) begin
            rise_active_ff <= rise_shadow_ff;
         end else if (ld_ff && fall_evt) begin
            fall_active_ff <= fall_shadow_ff;
         end
      end
   end

   // ----------------------------------------------------------------------
   // auto-shutdown and restart
   // ----------------------------------------------------------------------
   logic sd_wr;
   assign sd_wr = wr_fire && paddr_in == `CWU_OFF_SDCTRL0;

   // status bit: hardware set wins over any software clear
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sd_ff                <= 1'b0;
         ren_ff               <= 1'b0;
         bd_override_level_ff <= 2'h1;
         ac_override_level_ff <= 2'h1;
      end else if (clk_en_in) begin
         if (sd_wr) begin
            ren_ff               <= pwdata_in[`CWU_REN_BIT];
            bd_override_level_ff <= pwdata_in[`CWU_BD_LSB +: 2];
            ac_override_level_ff <= pwdata_in[`CWU_AC_LSB +: 2];
         end
         if (src_active) begin
            sd_ff <= 1'b1;
         end else if (sd_wr && pwdata_in[`CWU_SD_BIT]) begin
            sd_ff <= 1'b1;
         end else if (ren_ff) begin
            sd_ff <= 1'b0;
         end else if (sd_wr && !pwdata_in[`CWU_SD_BIT]) begin
            sd_ff <= 1'b0;
         end
      end
   end

   // restart tracking: overrides hold until a rising event after clearing
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_ff <= CWU_SHUT;
      end else if (clk_en_in) begin
         case (state_ff)
            CWU_RUN: begin
               if (sd_ff || src_active) begin
                  state_ff <= CWU_SHUT;
               end
            end
            CWU_SHUT: begin
               if (!sd_ff && !src_active) begin
                  state_ff <= CWU_WAIT;
               end
            end
            CWU_WAIT: begin
               if (sd_ff || src_active) begin
                  state_ff <= CWU_SHUT;
               end else if (rise_evt && en_ff) begin
                  state_ff <= CWU_RUN;
               end
            end
            default: state_ff <= CWU_SHUT;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // dead-band engine
   // ----------------------------------------------------------------------
   // counts clock periods from the loaded value; a short input pulse that
   // ends before the count runs out leaves the delayed output inactive
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         data_d_ff  <= 1'b0;
         cnt_ff     <= '0;
         rise_ok_ff <= 1'b0;
         fall_ok_ff <= 1'b1;
         fwd_ff     <= 1'b1;
      end else if (clk_en_in) begin
         data_d_ff <= data_in;
         if (rise_evt) begin
            cnt_ff     <= rise_active_ff;
            rise_ok_ff <= rise_active_ff == '0;
            fall_ok_ff <= 1'b0;
            fwd_ff     <= mode_ff != CWU_REV_FULL;
         end else if (fall_evt) begin
            cnt_ff     <= fall_active_ff;
            fall_ok_ff <= fall_active_ff == '0;
            rise_ok_ff <= 1'b0;
         end else if (cnt_ff != '0) begin
            cnt_ff <= cnt_ff - 1'b1;
            if (cnt_ff == 1 && data_d_ff) begin
               rise_ok_ff <= 1'b1;
            end
            if (cnt_ff == 1 && !data_d_ff) begin
               fall_ok_ff <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // mode steering, polarity, override
   // ----------------------------------------------------------------------
   logic [3:0] raw;
   logic [3:0] lvl;
   logic [3:0] oe;

   // raw waveform per output, bit order D C B A
   always_comb begin
      raw = 4'h0;
      case (mode_ff)
         CWU_STEER, CWU_SYNC_STEER: raw = {4{data_in}};
         // a and c follow the input after the rising band, b and d its
         // complement after the falling band
         CWU_HALF:      raw = {fall_ok_ff & ~data_in, rise_ok_ff & data_in,
                               fall_ok_ff & ~data_in, rise_ok_ff & data_in};
         CWU_PUSH_PULL: raw = {fall_ok_ff & ~data_in, rise_ok_ff & data_in,
                               fall_ok_ff & ~data_in, rise_ok_ff & data_in};
         CWU_FWD_FULL:  raw = {rise_ok_ff & data_in, 1'b0, 1'b0, 1'b1};
         CWU_REV_FULL:  raw = {1'b1, 1'b0, rise_ok_ff & data_in, 1'b0};
         default:       raw = 4'h0;
      endcase
   end

   // per-output polarity and override selection
   for (genvar i = 0; i < 4; i++) begin : g_out
      // one code per output so no two processes drive the same variable
      logic [1:0] code;
      always_comb begin
         code = (i % 2 == 1) ? bd_override_level_ff : ac_override_level_ff;
         if (!en_ff && !sd_ff) begin
            lvl[i] = 1'b0;
            oe[i]  = 1'b0;
         end else if (state_ff != CWU_RUN) begin
            oe[i] = code != `CWU_OVR_HIZ;
            case (code)
               `CWU_OVR_HIGH: lvl[i] = 1'b1;
               `CWU_OVR_LOW:  lvl[i] = 1'b0;
               `CWU_OVR_HIZ:  lvl[i] = 1'b0;
               default:       lvl[i] = pol_ff[i]; // inactive incl. polarity
            endcase
         end else begin
            lvl[i] = raw[i] ^ pol_ff[i];
            oe[i]  = 1'b1;
         end
      end
   end

   // registered pins
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         out_level_out <= 4'h0;
         out_oe_out    <= 4'h0;
      end else if (clk_en_in) begin
         out_level_out <= lvl;
         out_oe_out    <= oe;
      end
   end

endmodule
`default_nettype wire

/* test/cwu_src_model.sv */
/* far side: modulating source and active-low fault sources.
 assumes the bench sets the wanted levels off the clock edge. */
`timescale 1ns/1ps
`default_nettype none
module cwu_src_model (
   input  wire logic       clock_in,
   input  wire logic       data_req_in,
   input  wire logic [5:0] fault_in,
   output logic            data_out = 1'b0,
   output logic [5:0]      src_n_out = 6'h3F
);
   // ------------------------------------------------------------
   // registered so every change lands just after an edge
   // ------------------------------------------------------------
   always_ff @(posedge clock_in) begin
      data_out  <= data_req_in;
      src_n_out <= ~fault_in;
   end
endmodule
`default_nettype wire

/* test/cwu_top_bench.sv */
/* self-checking bench: apb master, register model and pin checks.
 assumes cwu_top, its defs header and the source model are compiled. */
`include "cwu_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module cwu_top_bench;
   // ------------------------------------------------------------
   // stimulus, model and checks
   // ------------------------------------------------------------
   logic        clock_in = 1'b0;
   logic        rst_n_in = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        data_w;
   logic        data_req = 1'b0;
   logic [5:0]  fault = 6'h00;
   logic [5:0]  src_n;
   logic [3:0]  lvl;
   logic [3:0]  oe;
   int          bad_count = 0;
   int          total_checks = 0;
   int          k;
   int          mreg[6];
   logic [31:0] v;
   logic [31:0] wmask[6] = '{32'h3B, 32'hFF, 32'hFF, 32'hFF, 32'h7F, 32'hFF};
   logic [31:0] rmask[6] = '{32'h07, 32'h0F, 32'h3F, 32'h3F, 32'h7C, 32'h3F};
   initial forever #5 clock_in = ~clock_in;
   cwu_src_model cwu_src_model_inst (.clock_in(clock_in), .data_req_in(data_req),
      .fault_in(fault), .data_out(data_w), .src_n_out(src_n));
   cwu_top cwu_top_inst (.clock_in(clock_in), .rst_n_in(rst_n_in),
      .clk_en_in(1'b1), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
      .data_in(data_w), .shutdown_src_n_in(src_n), .out_level_out(lvl),
      .out_oe_out(oe));
   task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t reg got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmp_pin(input logic [3:0] got, input logic [3:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t pin got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clock_in);
   endtask
   // setup, then access held until ready is sampled high
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic er);
      int n;
      n = 0;
      @(posedge clock_in);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock_in);
      penable <= 1'b1;
      do begin
         @(posedge clock_in);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) bad_count++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] x,
                      input logic ex);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      cmp_reg(r, x);
      cmp_reg({31'h0, e}, {31'h0, ex});
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      #200us;
      bad_count++;
      conclude();
   end
   initial begin
      v = $urandom(32'h1D56);
      tick(8);
      rst_n_in <= 1'b1;
      rdc(`CWU_OFF_CTRL0, 32'h00, 1'b0);
      rdc(`CWU_OFF_SDCTRL0, 32'h14, 1'b0);
      rdc(12'h020, 32'h00, 1'b1);
      $display("test reset values done");
      for (int i = 0; i < 6; i++) begin
         v = $urandom;
         mreg[i] = int'(v & wmask[i] & rmask[i]);
         wr(12'(i * 4), v & wmask[i]);
         rdc(12'(i * 4), 32'(mreg[i]), 1'b0);
      end
      $display("test field masks done");
      for (int m = 0; m < 6; m++) begin
         wr(`CWU_OFF_CTRL0, 32'(m));
         rdc(`CWU_OFF_CTRL0, 32'(m), 1'b0);
      end
      $display("test modes done");
      wr(`CWU_OFF_RISE_DB, 32'h02);
      wr(`CWU_OFF_FALL_DB, 32'h02);
      wr(`CWU_OFF_CTRL1, 32'h0F);
      wr(`CWU_OFF_CTRL0, 32'hC4);
      rdc(`CWU_OFF_CTRL0, 32'h84, 1'b0);
      wr(`CWU_OFF_CTRL0, 32'hC4);
      rdc(`CWU_OFF_CTRL0, 32'hC4, 1'b0);
      data_req <= 1'b1;
      tick(4);
      rdc(`CWU_OFF_CTRL0, 32'h84, 1'b0);
      $display("test load request done");
      k = $urandom % 6;
      wr(`CWU_OFF_SDSEL, 32'(1 << k));
      wr(`CWU_OFF_SDCTRL0, 32'h2C);
      fault <= 6'(1 << k);
      tick(6);
      rdc(`CWU_OFF_SDCTRL0, 32'hAC, 1'b0);
      cmp_pin(lvl, 4'h5);
      cmp_pin(oe, 4'hF);
      wr(`CWU_OFF_SDCTRL0, 32'h2C);
      rdc(`CWU_OFF_SDCTRL0, 32'hAC, 1'b0);
      fault <= 6'h00;
      tick(4);
      wr(`CWU_OFF_SDCTRL0, 32'h2C);
      rdc(`CWU_OFF_SDCTRL0, 32'h2C, 1'b0);
      cmp_pin(lvl, 4'h5);
      data_req <= 1'b0;
      tick(4);
      data_req <= 1'b1;
      tick(20);
      cmp_pin({2'h0, lvl[1:0]}, 4'h2);
      $display("test software restart done");
      wr(`CWU_OFF_SDCTRL0, 32'h58);
      fault <= 6'(1 << k);
      tick(6);
      rdc(`CWU_OFF_SDCTRL0, 32'hD8, 1'b0);
      cmp_pin(oe, 4'h5);
      cmp_pin(lvl & 4'h5, 4'h0);
      fault <= 6'h00;
      tick(6);
      rdc(`CWU_OFF_SDCTRL0, 32'h58, 1'b0);
      $display("test auto restart done");
      wr(`CWU_OFF_CTRL0, 32'h04);
      wr(`CWU_OFF_SDCTRL0, 32'hAC);
      rdc(`CWU_OFF_SDCTRL0, 32'hAC, 1'b0);
      $display("test forced shutdown done");
      conclude();
   end
endmodule
`default_nettype wire

/* test/cwu_top_chk.sv */
/* port checker for cwu_top: apb timing and shutdown override levels.
 assumes clk_en_in held high and bound to every cwu_top instance. */
`include "cwu_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module cwu_top_chk (
   input wire logic        clock_in,
   input wire logic        rst_n_in,
   input wire logic        clk_en_in,
   input wire logic        psel_in,
   input wire logic        penable_in,
   input wire logic        pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [31:0] prdata_out,
   input wire logic        pready_out,
   input wire logic        pslverr_out,
   input wire logic        data_in,
   input wire logic [5:0]  shutdown_src_n_in,
   input wire logic [3:0]  out_level_out,
   input wire logic [3:0]  out_oe_out
);
   // ------------------------------------------------------------
   // shadow of enable, source select and override fields
   // ------------------------------------------------------------
   logic [5:0] sel_ff;
   logic [1:0] ac_ff;
   logic [1:0] bd_ff;
   logic       en_ff;
   logic       wr_done;
   logic       act;
   assign wr_done = psel_in & penable_in & pwrite_in & pready_out;
   assign act     = en_ff & (|(sel_ff & ~shutdown_src_n_in));
   // writes land on the same edge as in the design
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sel_ff <= 6'h00;
         ac_ff  <= 2'h1;
         bd_ff  <= 2'h1;
         en_ff  <= 1'b0;
      end else if (wr_done) begin
         if (paddr_in == `CWU_OFF_CTRL0) en_ff <= pwdata_in[7];
         if (paddr_in == `CWU_OFF_SDSEL) sel_ff <= pwdata_in[5:0];
         if (paddr_in == `CWU_OFF_SDCTRL0) begin
            ac_ff <= pwdata_in[3:2];
            bd_ff <= pwdata_in[5:4];
         end
      end
   end
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);
   sequence setup_s; psel_in && !penable_in; endsequence
   sequence access_s; psel_in && penable_in; endsequence
   // four-cycle hold: one cycle of margin over the two-cycle override latency
   sequence held_s; (act && !wr_done)[*4]; endsequence
   chk_one_wait: assert property (setup_s ##1 access_s |->
      !pready_out ##1 pready_out) else $error("ready not after one wait");
   chk_ready_pulse: assert property (pready_out |=> !pready_out)
      else $error("ready longer than one cycle");
   chk_ready_idle: assert property (!(psel_in && penable_in) |-> !pready_out)
      else $error("ready outside access phase");
   chk_err_unmapped: assert property (pready_out && paddr_in > 12'h014
      |-> pslverr_out) else $error("no error on unmapped address");
   chk_err_mapped: assert property (pready_out && paddr_in[1:0] == 2'h0 &&
      paddr_in <= 12'h014 |-> !pslverr_out) else $error("error on register");
   chk_rdata_upper: assert property (pready_out |-> prdata_out[31:8] == 24'h0)
      else $error("upper read data not zero");
   chk_ac_override: assert property (held_s ##0 ac_ff != 2'h0 |->
      out_oe_out[0] == ac_ff[1] && out_oe_out[2] == ac_ff[1] && (!ac_ff[1] ||
      out_level_out[0] == ac_ff[0] && out_level_out[2] == ac_ff[0]))
      else $error("a c override level wrong");
   chk_bd_override: assert property (held_s ##0 bd_ff != 2'h0 |->
      out_oe_out[1] == bd_ff[1] && out_oe_out[3] == bd_ff[1] && (!bd_ff[1] ||
      out_level_out[1] == bd_ff[0] && out_level_out[3] == bd_ff[0]))
      else $error("b d override level wrong");
endmodule
bind cwu_top cwu_top_chk cwu_top_chk_inst (.clock_in(clock_in),
   .rst_n_in(rst_n_in), .clk_en_in(clk_en_in), .psel_in(psel_in),
   .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
   .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
   .pslverr_out(pslverr_out), .data_in(data_in),
   .shutdown_src_n_in(shutdown_src_n_in), .out_level_out(out_level_out),
   .out_oe_out(out_oe_out));
`default_nettype wire
